// file: shared/dvc_defines.svh
/*
 * Offsets, field positions, reset values and counts of the DAC control core.
 * Assumes inclusion by bare name from the design file and the testbench.
 */
`ifndef DVC_DEFINES_SVH
`define DVC_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DVC_OFS_FMT 5'h00
`define DVC_OFS_SPD 5'h01
`define DVC_OFS_POL 5'h02
`define DVC_OFS_LVOL 5'h03
`define DVC_OFS_RVOL 5'h04
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define DVC_DEF_FMT 8'h8B
`define DVC_DEF_SPD 8'h02
`define DVC_DEF_POL 8'h00
`define DVC_DEF_VOL 8'hFF
`define DVC_B_TRST 0
`define DVC_B_PWR 1
`define DVC_B_AUTO 7
`define DVC_B_MUTE 0
`define DVC_B_ZCMB 6
`define DVC_B_ZEN 7
`define DVC_B_ZINV 2
`define DVC_B_INVR 3
`define DVC_B_INVL 4
`define DVC_CHIP_ADDR 2'h1
// ----------------------------------------
// Counts in frame clock periods
// ----------------------------------------
`define DVC_ZERO_FRAMES 14'h2000
`define DVC_TR_ENTER 3'h4
`define DVC_TR_LEAVE 3'h3
`define DVC_STEP_NORMAL 5'h04
`define DVC_STEP_DOUBLE 5'h08
`define DVC_STEP_QUAD 5'h10
`endif

// file: shared/dvc_pkg.sv
/*
 * Types shared by the DAC control core.
 * Assumes the defines header is on the include path.
 */
`default_nettype none
package dvc_pkg;
    // ----------------------------------------
    // Control frame and sample carriers
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] chip;  // Chip address bits
        logic rw;          // Write marker
        logic [4:0] addr;  // Register address
        logic [7:0] data;  // Register data
    } dvc_word_t;
    typedef struct packed {
        logic [23:0] left;   // Left sample
        logic [23:0] right;  // Right sample
    } dvc_pair_t;
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_RUN = 2'b10
    } dvc_pwr_t;
endpackage : dvc_pkg
`default_nettype wire

// file: hdl/dvc_core.sv
/*
 * Control core of a two-channel audio DAC: serial control port, register
 * bank, soft volume and mute ramps, zero-data flags, power and timing reset.
 * Assumes samples arrive already deserialised on clk, one pulse per frame,
 * and that master clock presence and auto speed come from logic on clk.
 */
`default_nettype none
`include "dvc_defines.svh"

module dvc_core (
    input wire logic clk,                        // Core clock
    input wire logic srst,                       // Sync reset, high
    input wire logic control_shift_clock,        // Control port clock
    input wire logic control_select_n,           // Select, or mute pin
    input wire logic control_serial_in,          // Control port data
    input wire logic power_down_n,               // Power-down pin, low
    input wire logic frame_clock,                // Frame clock pin
    input wire logic serial_mode_n,              // Low selects serial
    input wire logic master_clock_present,       // Master clock seen
    input wire logic [1:0] auto_speed,           // Detected speed
    input wire dvc_pkg::dvc_pair_t sample_in,    // Input samples
    input wire logic sample_valid,               // One per frame
    output dvc_pkg::dvc_pair_t sample_out,       // Scaled samples
    output logic out_valid,                      // Output strobe
    output logic analog_float,                   // Outputs floating
    output logic analog_mid,                     // Outputs at mid level
    output logic left_zero_flag,                 // Left zero flag
    output logic right_zero_flag                 // Right zero flag
);
    import dvc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [15:0] shift_r;          // Link side shift register
    logic csn_s1_r, csn_s2_r, csn_d_r;  // Select synchroniser
    logic pdn_s1_r, pdn_s2_r;      // Power-down synchroniser
    logic fc_s1_r, fc_s2_r, fc_d_r;     // Frame clock synchroniser
    logic psm_s1_r, psm_s2_r;      // Mode pin synchroniser
    logic [7:0] fmt_r, spd_r, pol_r;  // Control registers
    logic [7:0] vol_r [0:1];       // Volume codes, by channel
    logic [7:0] level_r [0:1];     // Live volume levels
    logic [13:0] zcnt_r [0:1];     // Zero frame counters
    logic [2:0] tr_cnt_r;          // Timing reset delay count
    logic tr_int_r;                // Internal timing reset, low active
    logic [4:0] step_cnt_r;        // Frames within a step
    dvc_pwr_t pwr_r, pwr_nxt;      // Power sequence
    dvc_word_t word;               // Word seen at frame end
    logic ser, frame_tick, frame_fall, write_fire, step_tick;
    logic active, mute, zen, force_hi;
    logic [1:0] speed;
    logic [7:0] target [0:1];
    logic zl, zr, raw_l, raw_r;
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Frames per level step for a speed code
    function automatic logic [4:0] step_len(input logic [1:0] s);
        logic [4:0] n;
        n = `DVC_STEP_NORMAL;
        if (s == 2'h1) begin
            n = `DVC_STEP_DOUBLE;
        end else if (s[1]) begin
            n = `DVC_STEP_QUAD;
        end
        return n;
    endfunction : step_len
    // Linear gain code/255, built as x*(1+1/256)/256 to avoid a divider
    function automatic logic [23:0] scale(input logic [23:0] s,
                                          input logic [7:0] g, input logic inv);
        logic signed [32:0] p;
        logic [23:0] r;
        p = 33'($signed(s) * $signed({1'b0, g}));
        p = p + (p >>> 8);
        r = p[31:8];
        // Negating full-scale negative wraps; left as is
        return inv ? 24'(-r) : r;
    endfunction : scale
    // ----------------------------------------
    // Link domain: shift in control bits
    // ----------------------------------------
    // Shift on rising edge only while selected; the last 16 bits win
    always_ff @(posedge control_shift_clock) begin
        if (!control_select_n) begin
            shift_r <= {shift_r[14:0], control_serial_in};
        end
    end
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Two flops per pin, the first read only by the second
    always_ff @(posedge clk) begin
        csn_s1_r <= control_select_n;
        csn_s2_r <= csn_s1_r;
        csn_d_r <= csn_s2_r;
        pdn_s1_r <= power_down_n;
        pdn_s2_r <= pdn_s1_r;
        fc_s1_r <= frame_clock;
        fc_s2_r <= fc_s1_r;
        fc_d_r <= fc_s2_r;
        psm_s1_r <= serial_mode_n;
        psm_s2_r <= psm_s1_r;
    end
    // ----------------------------------------
    // Decode and effective controls
    // ----------------------------------------
    // Shift register is quiet once select is high; read it after two flops
    always_comb begin
        word = dvc_word_t'(shift_r);
        ser = !psm_s2_r;
        frame_tick = fc_s2_r && !fc_d_r;
        frame_fall = !fc_s2_r && fc_d_r;
        write_fire = csn_s2_r && !csn_d_r && ser && pdn_s2_r
            && master_clock_present;
        // Pin mode: select pin doubles as mute, no zero detect
        mute = ser ? spd_r[`DVC_B_MUTE] : csn_s2_r;
        zen = ser && spd_r[`DVC_B_ZEN];
        speed = 2'h0;
        if (ser) begin
            speed = fmt_r[`DVC_B_AUTO] ? auto_speed : spd_r[4:3];
        end
        active = (pwr_r == PWR_RUN) && tr_int_r
            && (!ser || fmt_r[`DVC_B_PWR]);
        force_hi = ser && (!fmt_r[`DVC_B_TRST] || !tr_int_r);
        step_tick = active && frame_tick
            && (step_cnt_r == 5'(step_len(speed) - 5'h01));
        for (int i = 0; i < 2; i++) begin
            target[i] = mute ? 8'h00 : vol_r[i];
        end
    end
    // ----------------------------------------
    // Register bank
    // ----------------------------------------
    // Pin low restores defaults; writes need the pin high, serial mode, master clock, matching chip bits and the write marker
    always_ff @(posedge clk) begin
        if (srst || !pdn_s2_r) begin
            fmt_r <= `DVC_DEF_FMT;
            spd_r <= `DVC_DEF_SPD;
            pol_r <= `DVC_DEF_POL;
            vol_r[0] <= `DVC_DEF_VOL;
            vol_r[1] <= `DVC_DEF_VOL;
        end else if (write_fire && word.chip == `DVC_CHIP_ADDR && word.rw) begin
            // Addresses above the map are dropped
            if (word.addr == `DVC_OFS_FMT) begin
                fmt_r <= word.data;
            end else if (word.addr == `DVC_OFS_SPD) begin
                spd_r <= word.data;
            end else if (word.addr == `DVC_OFS_POL) begin
                pol_r <= word.data;
            end else if (word.addr == `DVC_OFS_LVOL || word.addr == `DVC_OFS_RVOL) begin
                vol_r[1'(word.addr - `DVC_OFS_LVOL)] <= word.data;
            end
        end
    end
    // ----------------------------------------
    // Power sequence
    // ----------------------------------------
    // Start only on a falling frame edge with master clock present
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PWR_OFF: begin
                if (pdn_s2_r) begin
                    pwr_nxt = PWR_WAIT;
                end
            end
            PWR_WAIT: begin
                if (!pdn_s2_r) begin
                    pwr_nxt = PWR_OFF;
                end else if (master_clock_present && frame_fall) begin
                    pwr_nxt = PWR_RUN;
                end
            end
            PWR_RUN: begin
                if (!pdn_s2_r) begin
                    pwr_nxt = PWR_OFF;
                end else if (!master_clock_present) begin
                    pwr_nxt = PWR_WAIT;
                end
            end
            default: begin
                pwr_nxt = PWR_OFF;
            end
        endcase
    end
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_r <= PWR_OFF;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end
    // ----------------------------------------
    // Internal timing reset
    // ----------------------------------------
    // Follows the bit: in after four frame edges (3-4 periods), out after three (2-3)
    always_ff @(posedge clk) begin
        if (srst || !pdn_s2_r) begin
            tr_int_r <= 1'b1;
            tr_cnt_r <= 3'h0;
        end else if ((!ser || fmt_r[`DVC_B_TRST]) == tr_int_r) begin
            tr_cnt_r <= 3'h0;
        end else if (frame_tick) begin
            if (3'(tr_cnt_r + 3'h1) == (tr_int_r ? `DVC_TR_ENTER : `DVC_TR_LEAVE)) begin
                tr_int_r <= !tr_int_r;
                tr_cnt_r <= 3'h0;
            end else begin
                tr_cnt_r <= 3'(tr_cnt_r + 3'h1);
            end
        end
    end
    // ----------------------------------------
    // Volume ramps
    // ----------------------------------------
    // Step counter shared by both channels
    always_ff @(posedge clk) begin
        if (srst || !active) begin
            step_cnt_r <= 5'h00;
        end else if (step_tick) begin
            step_cnt_r <= 5'h00;
        end else if (frame_tick) begin
            step_cnt_r <= 5'(step_cnt_r + 5'h01);
        end
    end
    // One level per step toward the target; a new target turns the ramp where it stands
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (srst || !pdn_s2_r) begin
                level_r[i] <= `DVC_DEF_VOL;
            end else if (step_tick) begin
                if (level_r[i] < target[i]) begin
                    level_r[i] <= 8'(level_r[i] + 8'h01);
                end else if (level_r[i] > target[i]) begin
                    level_r[i] <= 8'(level_r[i] - 8'h01);
                end
            end
        end
    end
    // ----------------------------------------
    // Sample path
    // ----------------------------------------
    // Scaled samples; zero (mid-supply) while not running
    always_ff @(posedge clk) begin
        if (srst) begin
            sample_out <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= sample_valid && active;
            if (!active) begin
                sample_out <= '0;
            end else if (sample_valid) begin
                sample_out.left <= scale(sample_in.left, level_r[0],
                                         pol_r[`DVC_B_INVL]);
                sample_out.right <= scale(sample_in.right, level_r[1],
                                          pol_r[`DVC_B_INVR]);
            end
        end
    end
    // Analog state indicators
    always_ff @(posedge clk) begin
        if (srst) begin
            analog_float <= 1'b1;
            analog_mid <= 1'b0;
        end else begin
            analog_float <= !pdn_s2_r;
            analog_mid <= pdn_s2_r && !active;
        end
    end
    // ----------------------------------------
    // Zero detection
    // ----------------------------------------
    // Count zero frames, saturate at the limit, clear on any nonzero
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (srst || !active) begin
                zcnt_r[i] <= 14'h0000;
            end else if (sample_valid) begin
                if ((i == 0 ? sample_in.left : sample_in.right) != 24'h000000) begin
                    zcnt_r[i] <= 14'h0000;
                end else if (zcnt_r[i] != `DVC_ZERO_FRAMES) begin
                    zcnt_r[i] <= 14'(zcnt_r[i] + 14'h0001);
                end
            end
        end
    end
    // Flag selection; the flag drops one cycle after a nonzero sample clears the count
    always_comb begin
        zl = (zcnt_r[0] == `DVC_ZERO_FRAMES);
        zr = (zcnt_r[1] == `DVC_ZERO_FRAMES);
        raw_l = spd_r[`DVC_B_ZCMB] ? (zl && zr) : zl;
        raw_r = spd_r[`DVC_B_ZCMB] ? (zl && zr) : zr;
    end
    // Pin low wins, then disable, then timing reset, then detection
    always_ff @(posedge clk) begin
        if (srst || !pdn_s2_r) begin
            left_zero_flag <= 1'b0;
            right_zero_flag <= 1'b0;
        end else if (!zen) begin
            left_zero_flag <= 1'b0;
            right_zero_flag <= 1'b0;
        end else if (force_hi) begin
            left_zero_flag <= 1'b1;
            right_zero_flag <= 1'b1;
        end else begin
            left_zero_flag <= raw_l ^ pol_r[`DVC_B_ZINV];
            right_zero_flag <= raw_r ^ pol_r[`DVC_B_ZINV];
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_pdn_flags;
        !pdn_s2_r |=> !left_zero_flag && !right_zero_flag && analog_float;
    endproperty
    a_pdn_flags: assert property (p_pdn_flags) else $error("flags not low in power-down");
    property p_pdn_regs;
        !pdn_s2_r |=> fmt_r == `DVC_DEF_FMT && vol_r[0] == `DVC_DEF_VOL;
    endproperty
    a_pdn_regs: assert property (p_pdn_regs) else $error("registers not at default");
    property p_zen_off;
        pdn_s2_r && !zen |=> !left_zero_flag && !right_zero_flag;
    endproperty
    a_zen_off: assert property (p_zen_off) else $error("flags not held low when disabled");
    property p_force_hi;
        pdn_s2_r && zen && force_hi |=> left_zero_flag && right_zero_flag;
    endproperty
    a_force_hi: assert property (p_force_hi) else $error("flags not high in timing reset");
    property p_zero_set;
        pdn_s2_r && zen && !force_hi && !spd_r[`DVC_B_ZCMB]
            && zl |=> left_zero_flag == !$past(pol_r[`DVC_B_ZINV]);
    endproperty
    a_zero_set: assert property (p_zero_set) else $error("zero flag not raised");
    property p_nonzero;
        active && sample_valid && sample_in.left != 24'h000000 |=> zcnt_r[0] == 14'h0000;
    endproperty
    a_nonzero: assert property (p_nonzero) else $error("zero count not cleared");
    property p_combine;
        pdn_s2_r && zen && !force_hi && spd_r[`DVC_B_ZCMB] && !pol_r[`DVC_B_ZINV]
            && (zl != zr) |=> !left_zero_flag && !right_zero_flag;
    endproperty
    a_combine: assert property (p_combine) else $error("combined flag set on one channel");
    property p_step_time;
        $changed(level_r[0]) && $past(pdn_s2_r) |-> $past(step_tick);
    endproperty
    a_step_time: assert property (p_step_time) else $error("level moved off a step");
    property p_step_size;
        $past(pdn_s2_r) && $changed(level_r[1])
            |-> (8'(level_r[1] - $past(level_r[1])) == 8'h01)
             || (8'($past(level_r[1]) - level_r[1]) == 8'h01);
    endproperty
    a_step_size: assert property (p_step_size) else $error("level moved by more than one");
    property p_mute_down;
        step_tick && mute && level_r[0] != 8'h00 |=> level_r[0] == 8'($past(level_r[0]) - 8'h01);
    endproperty
    a_mute_down: assert property (p_mute_down) else $error("mute ramp did not step down");
    property p_write_only_on_select;
        $changed(vol_r[0]) && $past(pdn_s2_r) |-> $past(write_fire);
    endproperty
    a_write_only_on_select: assert property (p_write_only_on_select) else $error("write without select edge");
    c_mute_ramp: cover property (mute && step_tick && level_r[0] == 8'h01);
    c_zero_flag: cover property (zen && zl && !force_hi);
    c_timing_reset: cover property ($fell(tr_int_r));
    c_start: cover property (pwr_r == PWR_WAIT && pwr_nxt == PWR_RUN);
endmodule : dvc_core
`default_nettype wire

// file: tb/dvc_host.sv
/* Host model that writes control frames into the three-wire port.
   Assumes the bench calls send only while select is idle high. */
`default_nettype none
module dvc_host (
    output var logic control_shift_clock, // Shift clock, idle high
    output var logic control_select_n,    // Frame select, low
    output var logic control_serial_in    // Serial data
);
    timeunit 1ns;
    timeprecision 100ps;
    import dvc_pkg::*;
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        control_shift_clock = 1'b1;
        control_select_n = 1'b1;
        control_serial_in = 1'b0;
    end
    // ----------------------------------------
    // Frame sender, 15 ns shift clock
    // ----------------------------------------
    // Clock only runs inside a frame; data is inverted on release so a
    // stale bit can never pass for a real one
    task automatic send(input dvc_word_t w);
        control_select_n = 1'b0;
        #7.5;
        for (int i = 15; i >= 0; i--) begin
            control_shift_clock = 1'b0;
            control_serial_in = w[i];
            #7.5 control_shift_clock = 1'b1;
            #7.5;
        end
        control_select_n = 1'b1;
        control_serial_in = ~control_serial_in;
        #100;
    endtask : send
endmodule : dvc_host
`default_nettype wire

// file: tb/testbench.sv
/* Self-checking bench of the DAC control core with an integer model.
   Assumes the package, defines header and host model are compiled first. */
`default_nettype none
`include "dvc_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dvc_pkg::*;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    logic clk, srst, power_down_n, frame_clock, sample_valid;
    logic control_shift_clock, control_select_n, control_serial_in;
    logic out_valid, analog_float, analog_mid, left_zero_flag, right_zero_flag;
    logic serial_mode_n, master_clock_present;
    dvc_pair_t sample_in, sample_out;
    int fails = 0, num_checks = 0, seed = 32392;
    // Core clock and a frame clock of 16 core cycles
    always #4 clk = ~clk;
    always begin
        repeat (8) @(negedge clk);
        frame_clock = ~frame_clock;
    end
    dvc_host host (.control_shift_clock(control_shift_clock),
        .control_select_n(control_select_n), .control_serial_in(control_serial_in));
    dvc_core uut (.clk(clk), .srst(srst), .control_shift_clock(control_shift_clock),
        .control_select_n(control_select_n), .control_serial_in(control_serial_in),
        .power_down_n(power_down_n), .frame_clock(frame_clock),
        .serial_mode_n(serial_mode_n), .master_clock_present(master_clock_present),
        .auto_speed(2'h0), .sample_in(sample_in),
        .sample_valid(sample_valid), .sample_out(sample_out), .out_valid(out_valid),
        .analog_float(analog_float), .analog_mid(analog_mid),
        .left_zero_flag(left_zero_flag), .right_zero_flag(right_zero_flag));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Model of the volume stage, in plain integers
    function automatic logic [23:0] scl(input int s, input int lv);
        int p;
        p = s * lv;
        return 24'((p + (p >>> 8)) >>> 8);
    endfunction : scl
    // Random 24-bit signed sample
    function automatic int rs();
        int r;
        r = $random(seed);
        return r >>> 8;
    endfunction : rs
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] c = 2'h1);
        host.send({c, 1'b1, a, d});
        repeat (6) @(negedge clk);
    endtask : wr
    task automatic frames(input int n);
        repeat (n) @(posedge frame_clock);
    endtask : frames
    // One sample pair through the core, compared with the model
    task automatic put(input int sl, input int sr, input int ll, input int lr);
        int n;
        @(negedge clk);
        sample_in = {sl[23:0], sr[23:0]};
        sample_valid = 1'b1;
        @(negedge clk);
        sample_valid = 1'b0;
        n = 0;
        while (out_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        check("out_valid", {23'h0, out_valid}, 24'h1);
        check("left out", sample_out.left, scl(sl, ll));
        check("right out", sample_out.right, scl(sr, lr));
    endtask : put
    task automatic zeros(input int n);
        repeat (n) begin
            @(negedge clk);
            sample_in = '0;
            sample_valid = 1'b1;
            @(negedge clk);
            sample_valid = 1'b0;
        end
    endtask : zeros
    task automatic flags(input logic el, input logic er);
        repeat (3) @(negedge clk);
        check("left flag", {23'h0, left_zero_flag}, {23'h0, el});
        check("right flag", {23'h0, right_zero_flag}, {23'h0, er});
    endtask : flags
    task automatic complete_run;
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // Watchdog, some margin over the expected run
    // ----------------------------------------
    initial begin
        #790000;
        fails++;
        complete_run();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        power_down_n = 1'b1;
        serial_mode_n = 1'b0;
        master_clock_present = 1'b1;
        frame_clock = 1'b0;
        sample_in = '0;
        sample_valid = 1'b0;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        frames(4);
        put(rs(), rs(), 255, 255);
        wr(`DVC_OFS_LVOL, 8'h80);
        frames(600);
        put(rs(), rs(), 128, 255);
        // Refused words: bad chip bits, reserved address
        wr(`DVC_OFS_LVOL, 8'h00, 2'h2);
        wr(5'h05, 8'h00);
        frames(10);
        put(rs(), rs(), 128, 255);
        wr(`DVC_OFS_SPD, 8'h03);
        frames(1100);
        put(rs(), rs(), 0, 0);
        wr(`DVC_OFS_SPD, 8'h02);
        frames(1100);
        put(rs(), rs(), 128, 255);
        // Mute cancelled part way down
        wr(`DVC_OFS_SPD, 8'h03);
        frames(40);
        wr(`DVC_OFS_SPD, 8'h02);
        frames(90);
        put(rs(), rs(), 128, 255);
        // Zero detection at the count boundary
        wr(`DVC_OFS_SPD, 8'h82);
        zeros(8191);
        flags(1'b0, 1'b0);
        zeros(1);
        flags(1'b1, 1'b1);
        put(1000, 0, 128, 255);
        flags(1'b0, 1'b1);
        wr(`DVC_OFS_SPD, 8'hC2);
        flags(1'b0, 1'b0);
        wr(`DVC_OFS_POL, 8'h04);
        flags(1'b1, 1'b1);
        wr(`DVC_OFS_SPD, 8'h02);
        flags(1'b0, 1'b0);
        // Timing reset, with a write taken while it is held
        wr(`DVC_OFS_SPD, 8'h82);
        wr(`DVC_OFS_FMT, 8'h8A);
        frames(6);
        flags(1'b1, 1'b1);
        check("mid level", {23'h0, analog_mid}, 24'h1);
        wr(`DVC_OFS_POL, 8'h00);
        wr(`DVC_OFS_FMT, 8'h8B);
        frames(6);
        put(5, 5, 128, 255);
        flags(1'b0, 1'b0);
        check("mid level", {23'h0, analog_mid}, 24'h0);
        // Lost master clock: write dropped, restart on a frame edge
        master_clock_present = 1'b0;
        wr(`DVC_OFS_LVOL, 8'hFF);
        master_clock_present = 1'b1;
        frames(4);
        put(rs(), rs(), 128, 255);
        // Power-down pin: flags low, outputs float, registers back to defaults
        @(negedge clk);
        power_down_n = 1'b0;
        repeat (4) @(negedge clk);
        flags(1'b0, 1'b0);
        check("float", {23'h0, analog_float}, 24'h1);
        power_down_n = 1'b1;
        frames(4);
        put(rs(), rs(), 255, 255);
        check("float", {23'h0, analog_float}, 24'h0);
        // Pin mode entered across a power-down pulse; idle select means mute
        @(negedge clk);
        power_down_n = 1'b0;
        serial_mode_n = 1'b1;
        repeat (4) @(negedge clk);
        power_down_n = 1'b1;
        frames(1100);
        put(rs(), rs(), 0, 0);
        flags(1'b0, 1'b0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
